//--- rtl/sai_top.sv
`timescale 1ns/1ps
`default_nettype none
module sai_top #(
	parameter int BLINK_CYC = sai_pkg::BLINK_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       chip_rst_n,
	input  wire logic [1:0] led_mode,
	input  wire logic       link_speed_100,
	input  wire logic       indicator_speed_strap_pin_in,
	output logic            indicator_speed_strap_pin_out,
	output logic            indicator_speed_strap_pin_oe,
	output logic            speed_select,
	input  wire logic       link_clk,
	input  wire logic [3:0] rx_nibble,
	input  wire logic       rx_valid,
	output logic      [3:0] rxd,
	output logic            rxdv,
	input  wire logic [3:0] txd,
	input  wire logic       txen,
	output logic      [3:0] tx_nibble,
	output logic            tx_valid
);
	// ----------------------------------------------------------------
	// reset and strap capture (mclk)
	// ----------------------------------------------------------------
	logic crst_s1;
	logic crst_s2;
	logic pin_s1;
	logic pin_s2;
	logic sys_rst;
	logic rst_q;
	logic next_speed_select;
	logic next_oe;

	// pin synchronisers; a held-low chip reset pin keeps us in reset
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			crst_s1 <= 1'h0;
			crst_s2 <= 1'h0;
		end
		else
		begin
			crst_s1 <= chip_rst_n;
			crst_s2 <= crst_s1;
		end
		pin_s1 <= indicator_speed_strap_pin_in;
		pin_s2 <= pin_s1;
	end

	// [RULE5] active-low chip reset
	assign sys_rst = rst | ~crst_s2;

	// capture only on the release edge, so later pin activity is ignored
	always_comb
	begin
		next_speed_select = speed_select;
		// [RULE4] [RULE7] latch once at release
		if (rst_q && !sys_rst)
			next_speed_select = pin_s2;
		if (sys_rst)
			next_speed_select = speed_select;
		// [RULE6] input during reset, output after
		next_oe = ~sys_rst;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rst_q                        <= 1'h1;
			speed_select                 <= sai_pkg::STRAP_RESET;
			indicator_speed_strap_pin_oe <= 1'h0;
		end
		else
		begin
			rst_q                        <= sys_rst;
			speed_select                 <= next_speed_select;
			indicator_speed_strap_pin_oe <= next_oe;
		end
	end

	// ----------------------------------------------------------------
	// link side (link_clk)
	// ----------------------------------------------------------------
	logic       lrst_s1;
	logic       lrst;
	logic       txen_q;
	logic       act_tgl;
	logic [3:0] next_rxd;
	logic       next_rxdv;
	logic [3:0] next_tx_nibble;
	logic       next_tx_valid;
	logic       next_act_tgl;

	// reset level crossing into the link domain
	always_ff @(posedge link_clk)
	begin
		lrst_s1 <= sys_rst;
		lrst    <= lrst_s1;
	end

	// one toggle per cycle with a frame start in either direction; a toggle survives a stopped clock
	always_comb
	begin
		// [RULE8] [RULE9] nibble zeroed outside valid
		next_rxdv = rx_valid;
		next_rxd  = rx_valid ? rx_nibble : 4'h0;
		// [RULE11] take transmit data only under enable
		next_tx_valid  = txen;
		next_tx_nibble = txen ? txd : tx_nibble;
		next_act_tgl   = act_tgl ^ ((rx_valid & ~rxdv) | (txen & ~txen_q));
	end

	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			rxd       <= 4'h0;
			rxdv      <= 1'h0;
			tx_nibble <= 4'h0;
			tx_valid  <= 1'h0;
			txen_q    <= 1'h0;
			act_tgl   <= 1'h0;
		end
		else
		begin
			rxd       <= next_rxd;
			rxdv      <= next_rxdv;
			tx_nibble <= next_tx_nibble;
			tx_valid  <= next_tx_valid;
			txen_q    <= txen;
			act_tgl   <= next_act_tgl;
		end
	end

	// ----------------------------------------------------------------
	// indicator (mclk)
	// ----------------------------------------------------------------
	logic        act_s1;
	logic        act_s2;
	logic        act_s3;
	logic        act_evt;
	logic        tick;
	logic        pending;
	logic        led_act;
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic        next_pending;
	logic        next_led_act;
	logic        next_pin_out;

	always_ff @(posedge mclk)
	begin
		act_s1 <= act_tgl;
		act_s2 <= act_s1;
		act_s3 <= act_s2;
	end

	assign act_evt = act_s2 ^ act_s3;
	assign tick    = (cnt == 32'(BLINK_CYC - 1));

	// blink at a visible rate; short frames are remembered until the tick
	always_comb
	begin
		next_cnt     = tick ? 32'h0 : cnt + 32'h1;
		// a new event wins over the clear at the tick
		next_pending = act_evt | (pending & ~tick);
		next_led_act = led_act;
		// [RULE13] stretched blink
		if (tick)
			next_led_act = (pending | act_evt) ? ~led_act : sai_pkg::LED_OFF;
		// [RULE1] [RULE2] [RULE3] mode decode, reserved shows off
		case (led_mode)
			sai_pkg::MODE_SPEED:    next_pin_out = ~link_speed_100;
			sai_pkg::MODE_ACTIVITY: next_pin_out = led_act;
			default:                next_pin_out = sai_pkg::LED_OFF;
		endcase
		if (sys_rst)
			next_pin_out = sai_pkg::LED_OFF;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cnt                           <= 32'h0;
			pending                       <= 1'h0;
			led_act                       <= sai_pkg::LED_OFF;
			indicator_speed_strap_pin_out <= sai_pkg::LED_OFF;
		end
		else
		begin
			cnt                           <= next_cnt;
			pending                       <= next_pending;
			led_act                       <= next_led_act;
			indicator_speed_strap_pin_out <= next_pin_out;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence chip_low_s;
		!chip_rst_n [*3];
	endsequence
	sequence release_s;
		rst_q && !sys_rst;
	endsequence

	chip_reset_a: assert property (@(posedge mclk) disable iff (rst) chip_low_s |=> sys_rst) // [RULE5]
		else $error("chip reset pin low did not reset");
	strap_capture_a: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
		release_s |=> speed_select == $past(pin_s2))
		else $error("strap not captured at release");
	strap_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RULE7]
		!rst_q && !sys_rst |=> $stable(speed_select))
		else $error("strap changed after release");
	pin_dir_a: assert property (@(posedge mclk) disable iff (rst) // [RULE6]
		sys_rst |=> !indicator_speed_strap_pin_oe)
		else $error("pin driven during reset");
	// the release edge still registers the reset level, so the start needs a sampled low reset
	speed_led_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
		led_mode == sai_pkg::MODE_SPEED && !sys_rst |=> indicator_speed_strap_pin_out == !$past(link_speed_100))
		else $error("speed indicator wrong level");
	act_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE13]
		!$past(tick) && !$past(sys_rst) |-> $stable(led_act))
		else $error("activity indicator moved between ticks");
	act_idle_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
		tick && !pending && !act_evt |=> led_act == sai_pkg::LED_OFF)
		else $error("idle indicator not off");
	rx_gate_a: assert property (@(posedge link_clk) disable iff (lrst) !rxdv |-> rxd == 4'h0) // [RULE9]
		else $error("receive nibble present without valid");
	rx_follow_a: assert property (@(posedge link_clk) disable iff (lrst) // [RULE8]
		rx_valid && !lrst |=> rxdv && rxd == $past(rx_nibble))
		else $error("receive nibble not registered");
	tx_gate_a: assert property (@(posedge link_clk) disable iff (lrst) // [RULE11]
		!txen && !lrst |=> $stable(tx_nibble) && !tx_valid)
		else $error("transmit taken without enable");
	tx_take_a: assert property (@(posedge link_clk) disable iff (lrst) // [RULE11]
		txen && !lrst |=> tx_valid && tx_nibble == $past(txd))
		else $error("enabled transmit nibble not taken");
endmodule : sai_top
`default_nettype wire

//--- inc/sai_pkg.sv
// Notes on behaviour
// [RULE1] indicator behaviour chosen by a two-bit mode field
// [RULE2] mode 00 shows speed, high at 10 Mb/s; mode 01 shows activity, high idle
// [RULE3] mode codes 10 and 11 are reserved; software must not use them
// [RULE4] pin level at reset release is captured as the speed select bit
// [RULE5] chip reset input is active low, with a pull-up
// [RULE6] strap pin is an input during reset and drives its output afterwards
// [RULE7] straps latch once at reset release and are never re-sampled
// [RULE8] receive nibble changes only in step with the link clock
// [RULE9] receive nibble is valid only while receive valid is high
// [RULE10] MAC drives transmit nibble synchronous to the link clock
// [RULE11] MAC asserts transmit enable exactly while the nibble is valid; device takes only then
// [RULE12] MAC should not drive strap pins during reset; use strong external pulls otherwise
// [RULE13] activity toggling is stretched to a visible blink period
package sai_pkg;
	// ----------------------------------------------------------------
	// indicator modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SPEED     = 2'h0;
	localparam logic [1:0] MODE_ACTIVITY  = 2'h1;
	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic       STRAP_RESET    = 1'h1;	// internal pull-up: 100 Mb/s
	localparam logic       LED_OFF        = 1'h1;
	localparam int         MCLK_PERIOD_NS = 100;
	localparam int         BLINK_MS       = 50;
	localparam int         BLINK_CYCLES   = (BLINK_MS * 1000000) / MCLK_PERIOD_NS;
endpackage : sai_pkg

//--- verification/sai_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// mac end of the media independent interface
module sai_mac_model (
	input  wire logic       link_clk,
	input  wire logic [3:0] rxd,
	input  wire logic       rxdv,
	output logic      [3:0] txd,
	output logic            txen,
	output logic      [3:0] rx_last
);
	// strap kept free
	// this side never drives the strap pin
	initial
	begin
		txd = 4'h0;
		txen = 1'h0;
		rx_last = 4'h0;
	end
	always @(posedge link_clk)
		if (rxdv === 1'h1)
			rx_last <= rxd;
	// clocked enabled nibbles
	// data is inverted once enable drops, so a late capture is seen
	task automatic send(input logic [3:0] d, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge link_clk);
			txen <= 1'h1;
			txd  <= d + 4'(i);
		end
		@(posedge link_clk);
		txen <= 1'h0;
		txd  <= ~txd;
	endtask : send
endmodule : sai_mac_model
`default_nettype wire

//--- verification/speed_activity_indicator_strap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module speed_activity_indicator_strap_tb_top;
	logic       mclk = 1'h0, link_clk = 1'h0, rst = 1'h1, chip_rst_n = 1'h1, spd = 1'h1, strap = 1'h0;
	logic [1:0] mode = 2'h0;
	logic [3:0] rxn = 4'h0, txd, rxd, txn, rxl;
	logic       rxv = 1'h0, txen, rxdv, txv, pout, poe, ssel;
	int         mismatches = 0, n_checks = 0;
	// pin level: the outside pull wins only while the design lets go
	wire logic  pin = poe ? pout : strap;
	always #50 mclk = ~mclk;
	always #15 link_clk = ~link_clk;
	sai_top #(.BLINK_CYC(8)) dut (.mclk(mclk), .rst(rst), .chip_rst_n(chip_rst_n), .led_mode(mode),
		.link_speed_100(spd), .indicator_speed_strap_pin_in(pin), .indicator_speed_strap_pin_out(pout),
		.indicator_speed_strap_pin_oe(poe), .speed_select(ssel), .link_clk(link_clk), .rx_nibble(rxn),
		.rx_valid(rxv), .rxd(rxd), .rxdv(rxdv), .txd(txd), .txen(txen), .tx_nibble(txn), .tx_valid(txv));
	sai_mac_model mac (.link_clk(link_clk), .rxd(rxd), .rxdv(rxdv), .txd(txd), .txen(txen), .rx_last(rxl));
	task chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	// bounded wait for the indicator level, sampled mid-cycle
	task waitp(input logic v);
		for (int i = 0; i < 40 && pout !== v; i++) @(negedge mclk);
		chk(pout, v);
	endtask : waitp
	task t_strap;
		cyc(3);
		@(negedge mclk);
		chk(ssel, 4'h0);
		chk(poe, 4'h1);
	endtask : t_strap
	task t_speed;
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 2; s++)
			begin
				@(posedge mclk);
				mode <= 2'(m);
				spd  <= 1'(s);
				cyc(2);
				@(negedge mclk);
				chk(pout, (m == 0) ? 4'(s == 0) : 4'h1);
			end
		chk(ssel, 4'h0);
	endtask : t_speed
	task t_chip;
		@(posedge mclk);
		chip_rst_n <= 1'h0;
		strap      <= 1'h1;
		cyc(5);
		@(negedge mclk);
		chk(poe, 4'h0);
		@(posedge mclk);
		chip_rst_n <= 1'h1;
		cyc(6);
		@(negedge mclk);
		chk(ssel, 4'h1);
	endtask : t_chip
	task t_rx;
		@(posedge link_clk);
		rxv <= 1'h1;
		rxn <= 4'ha;
		@(posedge link_clk);
		rxv <= 1'h0;
		rxn <= 4'h3;
		@(negedge link_clk);
		chk(rxd, 4'ha);
		chk(rxdv, 4'h1);
		@(negedge link_clk);
		chk(rxd, 4'h0);
		chk(rxdv, 4'h0);
		chk(rxl, 4'ha);
	endtask : t_rx
	task t_tx;
		mac.send(4'h6, 3);
		@(negedge link_clk);
		chk(txn, 4'h8);
		chk(txv, 4'h1);
		@(negedge link_clk);
		chk(txn, 4'h8);
		chk(txv, 4'h0);
	endtask : t_tx
	task t_act;
		@(posedge mclk);
		mode <= 2'h1;
		cyc(20);
		waitp(1'h1);
		mac.send(4'h1, 4);
		waitp(1'h0);
		waitp(1'h1);
	endtask : t_act
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	// main sequence after the opening reset
	initial
	begin
		repeat (8) @(posedge mclk);
		rst <= 1'h0;
		t_strap;
		t_speed;
		t_chip;
		t_rx;
		t_tx;
		t_act;
		summarize;
	end
	// watchdog: the tests need well under a third of this span
	initial
	begin
		#100000;
		mismatches++;
		summarize;
	end
endmodule : speed_activity_indicator_strap_tb_top
`default_nettype wire
